// *** ecc_debug_map.svh ***
// register offsets, field positions, reset values and check masks of the debug unit
// Behaviour
// - software reads/writes raw data and check bits
// - debug access waits for all other traffic
// - debug request held during memory initialization
// - repair disable blocks single-error write-back
// - unrepaired read still corrects data, sets flag
// - debug write stores check bits as given
// - request set ignored while a request active
// - write request starts write at pointer
// - raw data and check stored, none computed
// - hardware clears write request when done
// - check bits: inverted masked parity, six masks
`ifndef ECC_DEBUG_MAP_SVH
`define ECC_DEBUG_MAP_SVH

`define OFS_CTRL 8'h00
`define OFS_POINTER 8'h04
`define OFS_DATA 8'h08
`define OFS_CHECK 8'h0c
`define OFS_STATUS 8'h10
`define OFS_MASK 8'h14

`define BIT_WRITE_REQ 0
`define BIT_READ_REQ 1
`define BIT_REPAIR_DIS 2
`define BIT_SINGLE_ERR 0
`define BIT_DOUBLE_ERR 1

`define CTRL_RESET 3'h0
`define MASK_RESET 2'h0

`define CHECK_MASK0 16'h443f
`define CHECK_MASK1 16'h13c7
`define CHECK_MASK2 16'he1d1
`define CHECK_MASK3 16'hee60
`define CHECK_MASK4 16'h3e8a
`define CHECK_MASK5 16'h993c

`endif

// *** ecc_debug_pkg.sv ***
// types shared by the debug access unit
package ecc_debug_pkg;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RD_WAIT,
    ST_RD_CHECK,
    ST_REPAIR,
    ST_DBG_WR,
    ST_DBG_RD
  } state_t;
endpackage

// *** sram_ecc_debug_access.sv ***
// sram ecc unit with debug raw access path, avalon-mm register slave
//
// Chosen here: the register offsets and the Avalon-MM slave port.
`timescale 1ns/1ps
`include "ecc_debug_map.svh"

module sram_ecc_debug_access (
  input wire logic MCLK, // 10 MHz bus clock
  input wire logic RST, // asynchronous reset, active high
  input wire logic [7:0] AVS_ADDRESS, // register byte address
  input wire logic AVS_READ, // register read strobe
  input wire logic AVS_WRITE, // register write strobe
  input wire logic [31:0] AVS_WRITEDATA, // register write data
  output logic [31:0] AVS_READDATA, // register read data
  output logic AVS_WAITREQUEST, // slave not ready
  input wire logic SYS_REQ, // normal access request
  input wire logic SYS_WE, // normal access is a write
  input wire logic [9:0] SYS_ADDR, // normal access word address
  input wire logic [15:0] SYS_WDATA, // normal write data
  output logic [15:0] SYS_RDATA, // corrected read data
  output logic SYS_ACK, // normal access done, one cycle
  input wire logic INIT_BUSY, // memory initialization running
  output logic MEM_EN, // memory strobe
  output logic MEM_WE, // memory write
  output logic [9:0] MEM_ADDR, // memory word address
  output logic [21:0] MEM_WDATA, // check bits over data
  input wire logic [21:0] MEM_RDATA, // stored word, one cycle after strobe
  output logic IRQ // level interrupt
);

  // check bit generator: inverted parity of data under each mask
  function automatic logic [5:0] check_of(input logic [15:0] d);
    check_of[0] = ~(^(d & `CHECK_MASK0));
    check_of[1] = ~(^(d & `CHECK_MASK1));
    check_of[2] = ~(^(d & `CHECK_MASK2));
    check_of[3] = ~(^(d & `CHECK_MASK3));
    check_of[4] = ~(^(d & `CHECK_MASK4));
    check_of[5] = ~(^(d & `CHECK_MASK5));
  endfunction

  ecc_debug_pkg::state_t state; // access sequencer
  ecc_debug_pkg::state_t next_state;
  logic write_req; // debug write request bit
  logic read_req; // debug read request bit
  logic repair_disable; // blocks single-error write-back
  logic [9:0] debug_pointer; // debug address
  logic [15:0] debug_raw_data; // raw data word
  logic [5:0] debug_raw_check; // raw check bits
  logic [1:0] status; // sticky error flags
  logic [1:0] mask; // interrupt enables
  logic [9:0] cur_addr; // address of normal access in flight
  logic [15:0] fixed_data; // corrected word for write-back
  logic [5:0] fixed_check; // check of corrected word
  logic [31:0] rd_mux; // read data selection
  logic bus_busy; // answer pending for next edge
  logic cur_is_sys; // read in flight is normal traffic
  logic fix_due; // write-back owed in the closing cycle

  // syndrome decode on the stored word
  wire [15:0] rd_data = MEM_RDATA[15:0];
  wire [5:0] syndrome = check_of(rd_data) ^ MEM_RDATA[21:16];
  wire no_err = (syndrome == 6'h00);
  logic [15:0] flip; // data bit to correct
  logic data_hit; // syndrome names a data bit
  logic check_hit; // syndrome names one check bit
  always_comb begin
    flip = 16'h0000;
    data_hit = 1'b0;
    for (int i = 0; i < 16; i++) begin
      if (syndrome == (check_of(16'h0001 << i) ^ check_of(16'h0000))) begin
        flip[i] = 1'b1;
        data_hit = 1'b1;
      end
    end
    check_hit = ($countones(syndrome) == 1);
  end
  wire single_err = !no_err && (data_hit || check_hit);
  wire double_err = !no_err && !single_err;
  wire [15:0] corrected = rd_data ^ flip;

  // register bus decode
  wire bus_acc = (AVS_READ || AVS_WRITE) && !bus_busy;
  // writes land only at the edge where the master sees waitrequest low
  wire wr_ctrl = AVS_WRITE && bus_busy && (AVS_ADDRESS == `OFS_CTRL);
  wire wr_ptr = AVS_WRITE && bus_busy && (AVS_ADDRESS == `OFS_POINTER);
  wire wr_data = AVS_WRITE && bus_busy && (AVS_ADDRESS == `OFS_DATA);
  wire wr_check = AVS_WRITE && bus_busy && (AVS_ADDRESS == `OFS_CHECK);
  wire wr_mask = AVS_WRITE && bus_busy && (AVS_ADDRESS == `OFS_MASK);
  wire rd_status = AVS_READ && !bus_busy && (AVS_ADDRESS == `OFS_STATUS);
  wire dbg_active = write_req || read_req;
  // a new request only lands while both request bits are clear
  wire set_wr = wr_ctrl && !dbg_active && AVS_WRITEDATA[`BIT_WRITE_REQ];
  wire set_rd = wr_ctrl && !dbg_active && !AVS_WRITEDATA[`BIT_WRITE_REQ]
    && AVS_WRITEDATA[`BIT_READ_REQ];
  // raw registers are frozen while a debug access owns them
  wire raw_wr_ok = !dbg_active;

  assign rd_mux =
    (AVS_ADDRESS == `OFS_CTRL) ? {29'h0, repair_disable, read_req, write_req} :
    (AVS_ADDRESS == `OFS_POINTER) ? {22'h0, debug_pointer} :
    (AVS_ADDRESS == `OFS_DATA) ? {16'h0, debug_raw_data} :
    (AVS_ADDRESS == `OFS_CHECK) ? {26'h0, debug_raw_check} :
    (AVS_ADDRESS == `OFS_STATUS) ? {30'h0, status} :
    (AVS_ADDRESS == `OFS_MASK) ? {30'h0, mask} : 32'h0;

  // sequencer events
  wire sys_go = (state == ecc_debug_pkg::ST_IDLE) && SYS_REQ && !INIT_BUSY;
  // debug waits for init end and for no normal request pending
  wire dbg_go = (state == ecc_debug_pkg::ST_IDLE) && !INIT_BUSY && !SYS_REQ;
  wire chk = (state == ecc_debug_pkg::ST_RD_CHECK);
  wire ev_single = chk && single_err;
  wire ev_double = chk && double_err;
  wire do_repair = chk && single_err && !repair_disable;
  wire dbg_rd_done = (state == ecc_debug_pkg::ST_DBG_RD);
  wire dbg_wr_done = (state == ecc_debug_pkg::ST_DBG_WR);
  // write-back goes out in the closing cycle, after the corrected word is captured
  wire repair_wr = (state == ecc_debug_pkg::ST_REPAIR) && fix_due;

  // next state of the sequencer
  always_comb begin
    next_state = state;
    unique case (state)
      ecc_debug_pkg::ST_IDLE: begin
        if (sys_go) begin
          // writes close at once; the closing cycle stops a held request being retaken
          next_state = SYS_WE ? ecc_debug_pkg::ST_REPAIR : ecc_debug_pkg::ST_RD_WAIT;
        end else if (dbg_go && write_req) begin
          next_state = ecc_debug_pkg::ST_DBG_WR;
        end else if (dbg_go && read_req) begin
          next_state = ecc_debug_pkg::ST_RD_WAIT;
        end
      end
      ecc_debug_pkg::ST_RD_WAIT: next_state = read_req && !cur_is_sys ?
        ecc_debug_pkg::ST_DBG_RD : ecc_debug_pkg::ST_RD_CHECK;
      ecc_debug_pkg::ST_RD_CHECK: begin
        next_state = ecc_debug_pkg::ST_REPAIR; // closing cycle, write-back if owed
      end
      ecc_debug_pkg::ST_REPAIR: next_state = ecc_debug_pkg::ST_IDLE;
      ecc_debug_pkg::ST_DBG_WR: next_state = ecc_debug_pkg::ST_IDLE;
      ecc_debug_pkg::ST_DBG_RD: next_state = ecc_debug_pkg::ST_IDLE;
    endcase
  end

  // marks whether the read in flight is normal traffic
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      cur_is_sys <= 1'b0;
    end else if (state == ecc_debug_pkg::ST_IDLE) begin
      cur_is_sys <= sys_go;
    end
  end

  // state register
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      state <= ecc_debug_pkg::ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // memory port: normal access, repair, raw debug write or debug read strobe
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      MEM_EN <= 1'b0;
      MEM_WE <= 1'b0;
      MEM_ADDR <= 10'h000;
      MEM_WDATA <= 22'h000000;
    end else begin
      MEM_EN <= 1'b0;
      MEM_WE <= 1'b0;
      if (sys_go) begin
        MEM_EN <= 1'b1;
        MEM_WE <= SYS_WE;
        MEM_ADDR <= SYS_ADDR;
        MEM_WDATA <= {check_of(SYS_WDATA), SYS_WDATA};
      end else if (dbg_go && write_req) begin
        MEM_EN <= 1'b1;
        MEM_WE <= 1'b1;
        MEM_ADDR <= debug_pointer;
        MEM_WDATA <= {debug_raw_check, debug_raw_data};
      end else if (dbg_go && read_req) begin
        MEM_EN <= 1'b1;
        MEM_ADDR <= debug_pointer;
      end else if (repair_wr) begin
        MEM_EN <= 1'b1;
        MEM_WE <= 1'b1;
        MEM_ADDR <= cur_addr;
        MEM_WDATA <= {fixed_check, fixed_data};
      end
    end
  end

  // capture address and corrected word for write-back
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      cur_addr <= 10'h000;
      fixed_data <= 16'h0000;
      fixed_check <= 6'h00;
      fix_due <= 1'b0;
    end else begin
      if (sys_go) begin
        cur_addr <= SYS_ADDR;
      end
      fixed_data <= corrected;
      fixed_check <= check_of(corrected);
      fix_due <= do_repair;
    end
  end

  // normal answer: write acks at once, read acks once the stored word has arrived
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      SYS_ACK <= 1'b0;
      SYS_RDATA <= 16'h0000;
    end else begin
      SYS_ACK <= (sys_go && SYS_WE) || chk;
      if (chk) begin
        SYS_RDATA <= corrected;
      end
    end
  end

  // control register and request bits
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      {repair_disable, read_req, write_req} <= `CTRL_RESET;
    end else begin
      if (wr_ctrl) begin
        repair_disable <= AVS_WRITEDATA[`BIT_REPAIR_DIS];
      end
      if (set_wr) begin
        write_req <= 1'b1;
      end else if (dbg_wr_done) begin
        write_req <= 1'b0;
      end
      if (set_rd) begin
        read_req <= 1'b1;
      end else if (dbg_rd_done) begin
        read_req <= 1'b0;
      end
    end
  end

  // pointer and raw data registers; debug read loads them uncorrected
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      debug_pointer <= 10'h000;
      debug_raw_data <= 16'h0000;
      debug_raw_check <= 6'h00;
    end else begin
      if (wr_ptr && raw_wr_ok) begin
        debug_pointer <= AVS_WRITEDATA[9:0];
      end
      if (wr_data && raw_wr_ok) begin
        debug_raw_data <= AVS_WRITEDATA[15:0];
      end
      if (wr_check && raw_wr_ok) begin
        debug_raw_check <= AVS_WRITEDATA[5:0];
      end
      if (dbg_rd_done) begin // the stored word stands on the memory bus now
        debug_raw_data <= MEM_RDATA[15:0];
        debug_raw_check <= MEM_RDATA[21:16];
      end
    end
  end

  // sticky flags: set wins over read-clear
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      status <= 2'h0;
      mask <= `MASK_RESET;
    end else begin
      if (wr_mask) begin
        mask <= AVS_WRITEDATA[1:0];
      end
      status[`BIT_SINGLE_ERR] <= ev_single || (status[`BIT_SINGLE_ERR] && !rd_status);
      status[`BIT_DOUBLE_ERR] <= ev_double || (status[`BIT_DOUBLE_ERR] && !rd_status);
    end
  end

  // interrupt: unmasked sticky flag
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= |(status & mask);
    end
  end

  // avalon answer: waitrequest high by default, low for one cycle per access
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      bus_busy <= 1'b0;
      AVS_WAITREQUEST <= 1'b1;
      AVS_READDATA <= 32'h0;
    end else begin
      bus_busy <= bus_acc;
      AVS_WAITREQUEST <= !bus_acc;
      if (bus_acc && AVS_READ) begin
        AVS_READDATA <= rd_mux;
      end
    end
  end

endmodule

// *** sram_ecc_debug_access_assertions.sv ***
// port-level checks of the sram ecc debug access unit
`timescale 1ns/1ps
`include "ecc_debug_map.svh"
module sram_ecc_debug_access_assertions (
  input wire logic MCLK, // bus clock
  input wire logic RST, // async reset
  input wire logic AVS_READ, // read strobe
  input wire logic AVS_WRITE, // write strobe
  input wire logic [7:0] AVS_ADDRESS, // byte address
  input wire logic [31:0] AVS_WRITEDATA, // write data
  input wire logic AVS_WAITREQUEST, // slave busy
  input wire logic SYS_REQ, // normal request
  input wire logic SYS_WE, // normal write
  input wire logic SYS_ACK, // normal done
  input wire logic INIT_BUSY, // init running
  input wire logic MEM_EN, // memory strobe
  input wire logic MEM_WE, // memory write
  input wire logic [21:0] MEM_WDATA, // stored word
  input wire logic IRQ // interrupt
);
  logic rep; // repair disable as last written
  logic [15:0] dd; // shadow of debug data
  logic [5:0] dc; // shadow of debug check bits
  wire done_wr = AVS_WRITE && !AVS_WAITREQUEST; // register write completing
  wire acc_any = AVS_READ || AVS_WRITE; // any register access
  // shadow control and debug registers at write completion
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      rep <= 1'b0;
      dd <= 16'h0;
      dc <= 6'h0;
    end else begin
      if (done_wr && AVS_ADDRESS == `OFS_CTRL) rep <= AVS_WRITEDATA[`BIT_REPAIR_DIS];
      if (done_wr && AVS_ADDRESS == `OFS_DATA) dd <= AVS_WRITEDATA[15:0];
      if (done_wr && AVS_ADDRESS == `OFS_CHECK) dc <= AVS_WRITEDATA[5:0];
    end
  end
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);
  a_wait_one_cycle: assert property ($fell(AVS_WAITREQUEST) |=> AVS_WAITREQUEST)
    else $error("wait low longer than one cycle");
  a_bus_answer: assert property (acc_any && AVS_WAITREQUEST |-> ##[1:2] !AVS_WAITREQUEST)
    else $error("register access not answered");
  a_init_hold: assert property (INIT_BUSY && !SYS_ACK |=> !MEM_EN)
    else $error("memory strobe during init");
  a_normal_first: assert property ((SYS_REQ && !SYS_WE && !SYS_ACK) ##1 MEM_EN |-> !MEM_WE)
    else $error("write ahead of pending normal read");
  a_repair_off: assert property (SYS_ACK && !SYS_WE && rep |=> !MEM_WE)
    else $error("write-back with repair disabled");
  a_read_latency: assert property (MEM_EN && !MEM_WE && $past(SYS_REQ) && !$past(SYS_WE) |=> ##1 SYS_ACK)
    else $error("normal read not acknowledged");
  a_irq_sticky: assert property (IRQ && !acc_any && !$past(acc_any) |=> IRQ)
    else $error("interrupt dropped without clear");
  a_debug_raw: assert property (MEM_EN && MEM_WE && !$past(SYS_REQ) |-> MEM_WDATA == {dc, dd})
    else $error("debug write word differs from registers");
endmodule
bind sram_ecc_debug_access sram_ecc_debug_access_assertions sram_ecc_debug_access_assertions_inst (
  .MCLK, .RST, .AVS_READ, .AVS_WRITE, .AVS_ADDRESS, .AVS_WRITEDATA, .AVS_WAITREQUEST,
  .SYS_REQ, .SYS_WE, .SYS_ACK, .INIT_BUSY, .MEM_EN, .MEM_WE, .MEM_WDATA, .IRQ);

// *** sram_array_model.sv ***
// behavioural model of the protected sram array
`timescale 1ns/1ps
module sram_array_model (
  input wire logic MCLK, // bus clock
  input wire logic MEM_EN, // strobe
  input wire logic MEM_WE, // write
  input wire logic [9:0] MEM_ADDR, // word address
  input wire logic [21:0] MEM_WDATA, // word to store
  output logic [21:0] MEM_RDATA // word read back
);
  logic [21:0] mem [1024]; // storage, reachable by the bench
  logic [21:0] last = 22'h0; // last word read
  logic vld = 1'b0; // read data valid this cycle
  // store writes, fetch reads for the following cycle
  always @(posedge MCLK) begin
    vld <= MEM_EN && !MEM_WE;
    if (MEM_EN && MEM_WE) mem[MEM_ADDR] <= MEM_WDATA;
    if (MEM_EN && !MEM_WE) last <= mem[MEM_ADDR];
  end
  // outside the valid cycle the bus shows the inverse, never a stale word
  assign MEM_RDATA = vld ? last : ~last;
  initial for (int i = 0; i < 1024; i++) mem[i] = 22'h0;
endmodule

// *** sram_ecc_debug_access_tb.sv ***
// self-checking bench of the sram ecc debug access unit
`timescale 1ns/1ps
`include "ecc_debug_map.svh"
module sram_ecc_debug_access_tb;
  logic MCLK = 1'b0, RST = 1'b1, AVS_READ = 1'b0, AVS_WRITE = 1'b0; // clock, reset, strobes
  logic SYS_REQ = 1'b0, SYS_WE = 1'b0, INIT_BUSY = 1'b0; // normal side, init
  logic [7:0] AVS_ADDRESS = 8'h0; // register address
  logic [31:0] AVS_WRITEDATA = 32'h0, AVS_READDATA, q; // bus data, last result
  logic [9:0] SYS_ADDR = 10'h0, MEM_ADDR; // addresses
  logic [15:0] SYS_WDATA = 16'h0, SYS_RDATA, d = 16'h5a3c; // data, test word
  logic [21:0] MEM_WDATA, MEM_RDATA; // memory words
  logic AVS_WAITREQUEST, SYS_ACK, MEM_EN, MEM_WE, IRQ; // design outputs
  int errors = 0, comparisons = 0; // tallies
  sram_ecc_debug_access sram_ecc_debug_access_inst (.MCLK, .RST, .AVS_ADDRESS, .AVS_READ,
    .AVS_WRITE, .AVS_WRITEDATA, .AVS_READDATA, .AVS_WAITREQUEST, .SYS_REQ, .SYS_WE, .SYS_ADDR,
    .SYS_WDATA, .SYS_RDATA, .SYS_ACK, .INIT_BUSY, .MEM_EN, .MEM_WE, .MEM_ADDR, .MEM_WDATA,
    .MEM_RDATA, .IRQ);
  sram_array_model sram_array_model_inst (.MCLK, .MEM_EN, .MEM_WE, .MEM_ADDR, .MEM_WDATA,
    .MEM_RDATA);
  initial forever #50 MCLK = ~MCLK;
  // expected check bits, worked out independently
  function automatic logic [5:0] ecc(input logic [15:0] v);
    ecc = {~^(v & 16'h993c), ~^(v & 16'h3e8a), ~^(v & 16'hee60), ~^(v & 16'he1d1),
      ~^(v & 16'h13c7), ~^(v & 16'h443f)};
  endfunction
  task test_done;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      errors++;
      $display("ERROR %0t seen %h expected %h", $time, s, e);
    end
  endtask
  // one register access, held until waitrequest is seen low
  task acc(input logic w, input logic [7:0] a, input logic [31:0] v);
    int n;
    @(posedge MCLK);
    AVS_WRITE <= w;
    AVS_READ <= !w;
    AVS_ADDRESS <= a;
    AVS_WRITEDATA <= v;
    n = 0;
    do begin @(posedge MCLK); n++; end while (AVS_WAITREQUEST !== 1'b0 && n < 40);
    if (n >= 40) begin errors++; test_done; end
    q = AVS_READDATA;
    AVS_READ <= 1'b0;
    AVS_WRITE <= 1'b0;
  endtask
  task rdchk(input logic [7:0] a, input logic [31:0] e);
    acc(1'b0, a, 32'h0);
    chk(q, e);
  endtask
  // poll both request bits until clear before a new request
  task idle;
    int n;
    n = 0;
    do begin acc(1'b0, `OFS_CTRL, 32'h0); n++; end while (q[1:0] !== 2'b00 && n < 20);
    if (n >= 20) begin errors++; test_done; end
  endtask
  // one normal access, request held until the acknowledge is seen
  task sys_acc(input logic w, input logic [9:0] a, input logic [15:0] v);
    int n;
    @(posedge MCLK);
    SYS_REQ <= 1'b1;
    SYS_WE <= w;
    SYS_ADDR <= a;
    SYS_WDATA <= v;
    n = 0;
    do begin @(posedge MCLK); n++; end while (SYS_ACK !== 1'b1 && n < 40);
    if (n >= 40) begin errors++; test_done; end
    q = {16'h0, SYS_RDATA};
    SYS_REQ <= 1'b0;
    SYS_WE <= 1'b0;
  endtask
  task sys_rd(input logic [9:0] a);
    sys_acc(1'b0, a, 16'h0);
  endtask
  task dw(input logic [9:0] a, input logic [15:0] v, input logic [5:0] c, input logic rep);
    acc(1'b1, `OFS_POINTER, {22'h0, a});
    acc(1'b1, `OFS_DATA, {16'h0, v});
    acc(1'b1, `OFS_CHECK, {26'h0, c});
    acc(1'b1, `OFS_CTRL, {29'h0, rep, 2'b01});
    idle;
  endtask
  initial begin
    repeat (3) @(posedge MCLK);
    RST <= 1'b0;
    rdchk(`OFS_CTRL, 32'h0);
    rdchk(`OFS_MASK, 32'h0);
    rdchk(8'h1c, 32'h0);
    // debug read held by init, second request refused meanwhile
    sram_array_model_inst.mem[7] = 22'h2a1234;
    INIT_BUSY <= 1'b1;
    acc(1'b1, `OFS_POINTER, 32'h7);
    acc(1'b1, `OFS_CTRL, 32'h2);
    acc(1'b1, `OFS_CTRL, 32'h1);
    rdchk(`OFS_CTRL, 32'h2);
    INIT_BUSY <= 1'b0;
    idle;
    rdchk(`OFS_DATA, 32'h1234);
    rdchk(`OFS_CHECK, 32'h2a);
    chk({10'h0, sram_array_model_inst.mem[7]}, 32'h2a1234);
    // single data error with repair disabled
    dw(10'h3, d ^ 16'h0100, ecc(d), 1'b1);
    chk({10'h0, sram_array_model_inst.mem[3]}, {10'h0, ecc(d), d ^ 16'h0100});
    acc(1'b1, `OFS_MASK, 32'h1);
    sys_rd(10'h3);
    chk(q, {16'h0, d});
    repeat (4) @(posedge MCLK);
    chk({31'h0, IRQ}, 32'h1);
    chk({10'h0, sram_array_model_inst.mem[3]}, {10'h0, ecc(d), d ^ 16'h0100});
    rdchk(`OFS_STATUS, 32'h1);
    repeat (2) @(posedge MCLK);
    chk({31'h0, IRQ}, 32'h0);
    // repair enabled: word rewritten with computed check bits
    acc(1'b1, `OFS_CTRL, 32'h0);
    sys_rd(10'h3);
    repeat (3) @(posedge MCLK);
    chk({10'h0, sram_array_model_inst.mem[3]}, {10'h0, ecc(d), d});
    rdchk(`OFS_STATUS, 32'h1);
    // double error, masked from the interrupt
    dw(10'h4, d ^ 16'h0003, ecc(d), 1'b0);
    sys_rd(10'h4);
    repeat (3) @(posedge MCLK);
    chk({31'h0, IRQ}, 32'h0);
    rdchk(`OFS_STATUS, 32'h2);
    // debug write waits behind a held normal read
    acc(1'b1, `OFS_POINTER, 32'h5);
    SYS_ADDR <= 10'h3;
    SYS_REQ <= 1'b1;
    acc(1'b1, `OFS_CTRL, 32'h1);
    rdchk(`OFS_CTRL, 32'h1);
    sys_rd(10'h3);
    idle;
    chk({10'h0, sram_array_model_inst.mem[5]}, {10'h0, ecc(d), d ^ 16'h0003});
    // normal write computes check bits, debug read returns them raw
    sys_acc(1'b1, 10'h9, d);
    acc(1'b1, `OFS_POINTER, 32'h9);
    acc(1'b1, `OFS_CTRL, 32'h2);
    idle;
    rdchk(`OFS_DATA, {16'h0, d});
    rdchk(`OFS_CHECK, {26'h0, ecc(d)});
    chk({10'h0, sram_array_model_inst.mem[9]}, {10'h0, ecc(d), d});
    test_done;
  end
endmodule
